/* logic/pai_pass_pipe.sv */
// Parameterised register pipe carrying ALU operations unmodified
`timescale 1ns/1ns
module pai_pass_pipe #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage_q [DEPTH];

    if (DEPTH < 1 || W < 1) begin : g_bad_param
        $error("pai_pass_pipe needs DEPTH and W of at least one");
    end

    // One stage per cycle, no change to the carried word
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_q[i] <= '0;
            end
        end else begin
            stage_q[0] <= din;
            for (int i = 1; i < DEPTH; i++) begin
                stage_q[i] <= stage_q[i-1];
            end
        end
    end

    assign dout = stage_q[DEPTH-1];
endmodule // pai_pass_pipe

/* logic/pai_pixel_alu_dram_interlock.sv */
// Pixel ALU pass-through pipe, tag and plane mask storage, block write engine
`timescale 1ns/1ns
module pai_pixel_alu_dram_interlock import pai_pkg::*; #(
    parameter int GB_W = GB_W_DEF
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pixel_alu_cmd_valid,
    input wire logic pixel_alu_write_select,
    input wire logic [ALU_OP_W-1:0] pixel_alu_opcode,
    input wire logic [DATA_W-1:0] pixel_alu_data_bus,
    input wire logic array_cmd_valid,
    input wire logic [AOP_W-1:0] array_opcode,
    input wire logic [GB_W-1:0] pbuf_read_data,
    output logic [BEAT_W-1:0] pbuf_read_index,
    output logic gbus_write_valid,
    output logic [GB_W-1:0] gbus_write_data,
    output logic [GB_W-1:0] gbus_write_enable,
    output logic [BEAT_W-1:0] gbus_beat,
    output logic wb_busy,
    output logic wb_refused,
    output logic [DATA_W-1:0] dirty_tag,
    output logic [DATA_W-1:0] plane_mask
);
    localparam int LANES = GB_W / DATA_W;

    if (GB_W < DATA_W || (GB_W % DATA_W) != 0) begin : g_bad_param
        $error("GB_W must be a whole multiple of the ALU data width");
    end

    // Mask replicated across every pixel lane of the global bus
    function automatic logic [GB_W-1:0] expand_mask(input logic [DATA_W-1:0] m);
        logic [GB_W-1:0] r;
        r = '0;
        for (int i = 0; i < LANES; i++) begin
            r[i*DATA_W +: DATA_W] = m;
        end
        return r;
    endfunction

    // Pixel ALU command decode; unknown codes do nothing
    function automatic pai_kind_t decode_alu(input logic we, input logic [ALU_OP_W-1:0] op);
        pai_kind_t k;
        k = PAI_KIND_NONE;
        if (we) begin
            case (op)
                ALU_OP_TAG_REPLACE: k = PAI_KIND_TAG_REPLACE;
                ALU_OP_TAG_OR: k = PAI_KIND_TAG_OR;
                ALU_OP_WREG_PLANE_MASK: k = PAI_KIND_MASK_WRITE;
                default: k = PAI_KIND_NONE;
            endcase
        end
        return k;
    endfunction

    // Array command decode into length and mask use
    function automatic pai_wb_req_t decode_array(input logic en, input logic [AOP_W-1:0] op);
        pai_wb_req_t r;
        r = '0;
        if (en) begin
            case (op)
                AOP_WB2_UNMASKED: r = '{valid: 1'b1, masked: 1'b0, beats: WB2_BEATS};
                AOP_WB2_MASKED: r = '{valid: 1'b1, masked: 1'b1, beats: WB2_BEATS};
                AOP_WB3_UNMASKED: r = '{valid: 1'b1, masked: 1'b0, beats: WB3_BEATS};
                AOP_WB3_MASKED: r = '{valid: 1'b1, masked: 1'b1, beats: WB3_BEATS};
                default: r = '0;
            endcase
        end
        return r;
    endfunction

    // Reset release through two flops
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Issue cycle: hold the decoded operation for the data cycle
    pai_kind_t cmd_kind_q;

    // command in n, data follows in n+1
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            cmd_kind_q <= PAI_KIND_NONE;
        end else if (pixel_alu_cmd_valid) begin
            cmd_kind_q <= decode_alu(pixel_alu_write_select, pixel_alu_opcode);
        end else begin
            cmd_kind_q <= PAI_KIND_NONE;
        end
    end

    // Data cycle: pair the operation with the word on the data bus
    pai_stage_t pipe_in;
    pai_stage_t pipe_out;

    // mask value is taken in the cycle after the command
    always_comb begin
        pipe_in.valid = (cmd_kind_q != PAI_KIND_NONE);
        pipe_in.kind = cmd_kind_q;
        pipe_in.data = pixel_alu_data_bus;
    end

    // four unmodified stages, n+2 through n+5
    pai_pass_pipe #(
        .W($bits(pai_stage_t)),
        .DEPTH(ROP_STAGES)
    ) u_pass_pipe (
        .clock(clock),
        .rst_n(rst_sync_q),
        .din(pipe_in),
        .dout(pipe_out)
    );

    logic [DATA_W-1:0] dirty_tag_q;
    logic [DATA_W-1:0] plane_mask_q;

    // Tag storage updated from the last stage, new value seen from n+6
    // replace or OR into the stored tag
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            dirty_tag_q <= TAG_RESET;
        end else if (pipe_out.valid && pipe_out.kind == PAI_KIND_TAG_REPLACE) begin
            dirty_tag_q <= pipe_out.data;
        end else if (pipe_out.valid && pipe_out.kind == PAI_KIND_TAG_OR) begin
            dirty_tag_q <= dirty_tag_q | pipe_out.data;
        end
    end

    // Plane mask loads only off the end of the pipe, never early
    // mask holds its old value until n+6
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            plane_mask_q <= MASK_RESET;
        end else if (pipe_out.valid && pipe_out.kind == PAI_KIND_MASK_WRITE) begin
            plane_mask_q <= pipe_out.data;
        end
    end

    assign dirty_tag = dirty_tag_q;
    assign plane_mask = plane_mask_q;

    // Block write engine
    pai_wb_state_t wb_state_q;
    logic [BEAT_W-1:0] wb_len_q;
    logic [BEAT_W-1:0] wb_beat_q;
    logic [DATA_W-1:0] wb_mask_q;
    pai_wb_req_t wb_req;
    logic wb_last;
    logic wb_accept;
    logic [DATA_W-1:0] issue_mask;

    assign wb_req = decode_array(array_cmd_valid, array_opcode);
    assign wb_last = (wb_state_q == PAI_WB_XFER) && (wb_beat_q == wb_len_q - 2'h1);
    // a new block may start on the last beat, so writes chain back to back
    assign wb_accept = wb_req.valid && (wb_state_q == PAI_WB_IDLE || wb_last);
    // Mask frozen at issue so one block never mixes two masks; this settles the
    // straddle case the controller is told to avoid
    // issue by n+3 samples the old mask
    // issue by n+2 samples the old mask
    // issue from n+6 samples the new mask
    assign issue_mask = wb_req.masked ? plane_mask_q : MASK_ALL;

    // bus beats follow acceptance with no gap
    // three-cycle variant holds the bus for three beats
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            wb_state_q <= PAI_WB_IDLE;
            wb_len_q <= '0;
            wb_beat_q <= '0;
            wb_mask_q <= MASK_ALL;
        end else begin
            case (wb_state_q)
                PAI_WB_IDLE: begin
                    if (wb_accept) begin
                        wb_state_q <= PAI_WB_XFER;
                        wb_len_q <= wb_req.beats;
                        wb_beat_q <= '0;
                        wb_mask_q <= issue_mask;
                    end
                end
                PAI_WB_XFER: begin
                    if (wb_accept) begin
                        wb_len_q <= wb_req.beats;
                        wb_beat_q <= '0;
                        wb_mask_q <= issue_mask;
                    end else if (wb_last) begin
                        wb_state_q <= PAI_WB_IDLE;
                        wb_beat_q <= '0;
                    end else begin
                        wb_beat_q <= wb_beat_q + 2'h1;
                    end
                end
                default: begin
                    wb_state_q <= PAI_WB_IDLE;
                end
            endcase
        end
    end

    // Beat the source must present before the next edge
    logic bus_load;
    logic [DATA_W-1:0] beat_mask;

    assign bus_load = wb_accept || (wb_state_q == PAI_WB_XFER && !wb_last);
    assign pbuf_read_index = wb_accept ? '0 : wb_beat_q + 2'h1;
    assign beat_mask = wb_accept ? issue_mask : wb_mask_q;

    logic gbus_valid_q;
    logic [GB_W-1:0] gbus_data_q;
    logic [GB_W-1:0] gbus_enable_q;
    logic [BEAT_W-1:0] gbus_beat_q;

    // Registered bus drive; mask gates both data and per-bit enable
    // each beat uses the mask captured at issue
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            gbus_valid_q <= 1'b0;
            gbus_data_q <= '0;
            gbus_enable_q <= '0;
            gbus_beat_q <= '0;
        end else if (bus_load) begin
            gbus_valid_q <= 1'b1;
            gbus_data_q <= pbuf_read_data & expand_mask(beat_mask);
            gbus_enable_q <= expand_mask(beat_mask);
            gbus_beat_q <= pbuf_read_index;
        end else begin
            gbus_valid_q <= 1'b0;
            gbus_data_q <= '0;
            gbus_enable_q <= '0;
            gbus_beat_q <= '0;
        end
    end

    // Commands arriving mid-block are dropped; flagged for one cycle
    logic wb_refused_q;

    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            wb_refused_q <= 1'b0;
        end else begin
            wb_refused_q <= wb_req.valid && !wb_accept;
        end
    end

    assign gbus_write_valid = gbus_valid_q;
    assign gbus_write_data = gbus_data_q;
    assign gbus_write_enable = gbus_enable_q;
    assign gbus_beat = gbus_beat_q;
    assign wb_busy = gbus_valid_q; // High on every bus beat
    assign wb_refused = wb_refused_q;
endmodule // pai_pixel_alu_dram_interlock

/* pkg/pai_pkg.sv */
// Shared constants and types for the pixel ALU and array write interlock
package pai_pkg;
    // Widths
    localparam int DATA_W = 32;
    localparam int GB_W_DEF = 256;
    localparam int ALU_OP_W = 4;
    localparam int AOP_W = 3;
    localparam int BEAT_W = 2;

    // Pass-through stages between data capture and storage write
    localparam int ROP_STAGES = 4;

    // Pixel ALU opcodes, taken with write select high
    localparam logic [ALU_OP_W-1:0] ALU_OP_TAG_REPLACE = 4'h1;
    localparam logic [ALU_OP_W-1:0] ALU_OP_TAG_OR = 4'h2;
    localparam logic [ALU_OP_W-1:0] ALU_OP_WREG_PLANE_MASK = 4'h3;

    // Array opcodes for block writes
    localparam logic [AOP_W-1:0] AOP_WB2_UNMASKED = 3'h1;
    localparam logic [AOP_W-1:0] AOP_WB2_MASKED = 3'h2;
    localparam logic [AOP_W-1:0] AOP_WB3_UNMASKED = 3'h3;
    localparam logic [AOP_W-1:0] AOP_WB3_MASKED = 3'h4;

    // Block lengths in global bus cycles
    localparam logic [BEAT_W-1:0] WB2_BEATS = 2'h2;
    localparam logic [BEAT_W-1:0] WB3_BEATS = 2'h3;

    // Reset values
    localparam logic [DATA_W-1:0] TAG_RESET = 32'h00000000;
    localparam logic [DATA_W-1:0] MASK_RESET = 32'hFFFFFFFF;
    localparam logic [DATA_W-1:0] MASK_ALL = 32'hFFFFFFFF;

    // Operation carried down the pass-through pipe
    typedef enum logic [1:0] {
        PAI_KIND_NONE = 2'h0,
        PAI_KIND_TAG_REPLACE = 2'h1,
        PAI_KIND_TAG_OR = 2'h2,
        PAI_KIND_MASK_WRITE = 2'h3
    } pai_kind_t;

    typedef struct packed {
        logic valid;
        pai_kind_t kind;
        logic [DATA_W-1:0] data;
    } pai_stage_t;

    // Decoded block write request
    typedef struct packed {
        logic valid;
        logic masked;
        logic [BEAT_W-1:0] beats;
    } pai_wb_req_t;

    // Block write engine states
    typedef enum logic [1:0] {
        PAI_WB_IDLE = 2'h1,
        PAI_WB_XFER = 2'h2
    } pai_wb_state_t;
endpackage

/* tb/pai_ctrl_model.sv */
// Rendering controller model issuing ALU and array commands
`timescale 1ns/1ns
module pai_ctrl_model import pai_pkg::*; #(
    parameter int GB_W = GB_W_DEF
) (
    input wire logic clock,
    input wire logic [BEAT_W-1:0] pbuf_read_index,
    output logic pixel_alu_cmd_valid,
    output logic pixel_alu_write_select,
    output logic [ALU_OP_W-1:0] pixel_alu_opcode,
    output logic [DATA_W-1:0] pixel_alu_data_bus,
    output logic array_cmd_valid,
    output logic [AOP_W-1:0] array_opcode,
    output logic [GB_W-1:0] pbuf_read_data
);
    // Source data carries its beat index, so a misordered beat shows
    assign pbuf_read_data = {(GB_W / DATA_W){24'h5A5A5A, 6'h00, pbuf_read_index}};
    initial begin
        {pixel_alu_cmd_valid, pixel_alu_write_select, array_cmd_valid} = 3'h0;
        pixel_alu_opcode = 4'h0;
        pixel_alu_data_bus = 32'h00000000;
        array_opcode = 3'h0;
    end
    // command one cycle, data the next
    task automatic step(input logic cv, input logic ws, input logic [ALU_OP_W-1:0] op,
        input logic dv, input logic [DATA_W-1:0] d, input logic av, input logic [AOP_W-1:0] aop);
        @(negedge clock);
        pixel_alu_cmd_valid = cv;
        pixel_alu_write_select = ws;
        pixel_alu_opcode = op;
        // Released data bus flips, never a stale copy
        pixel_alu_data_bus = dv ? d : ~pixel_alu_data_bus;
        array_cmd_valid = av;
        array_opcode = aop;
    endtask
endmodule // pai_ctrl_model

/* tb/pai_interlock_checker.sv */
// Port-level checks on the pixel ALU and block write interlock
`timescale 1ns/1ns
module pai_interlock_checker import pai_pkg::*; #(
    parameter int GB_W = GB_W_DEF
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pixel_alu_cmd_valid,
    input wire logic pixel_alu_write_select,
    input wire logic [ALU_OP_W-1:0] pixel_alu_opcode,
    input wire logic [DATA_W-1:0] pixel_alu_data_bus,
    input wire logic array_cmd_valid,
    input wire logic [AOP_W-1:0] array_opcode,
    input wire logic [GB_W-1:0] pbuf_read_data,
    input wire logic gbus_write_valid,
    input wire logic [GB_W-1:0] gbus_write_data,
    input wire logic [GB_W-1:0] gbus_write_enable,
    input wire logic [BEAT_W-1:0] gbus_beat,
    input wire logic wb_busy,
    input wire logic wb_refused,
    input wire logic [DATA_W-1:0] dirty_tag,
    input wire logic [DATA_W-1:0] plane_mask
);
    localparam int REP = GB_W / DATA_W;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Decoded requests; acceptance judged from idle only, chaining is covered apart
    wire logic alu_go = pixel_alu_cmd_valid && pixel_alu_write_select;
    wire logic wb_go = array_cmd_valid && !wb_busy;
    wire logic op2 = array_opcode == AOP_WB2_UNMASKED || array_opcode == AOP_WB2_MASKED;
    wire logic op3 = array_opcode == AOP_WB3_UNMASKED || array_opcode == AOP_WB3_MASKED;
    wire logic opm = array_opcode == AOP_WB2_MASKED || array_opcode == AOP_WB3_MASKED;
    property p_tag_rep;
        alu_go && pixel_alu_opcode == ALU_OP_TAG_REPLACE
            |-> ##6 dirty_tag == $past(pixel_alu_data_bus, 5);
    endproperty
    a_tag_rep: assert property (p_tag_rep) else $error("tag replace wrong");
    property p_tag_or;
        alu_go && pixel_alu_opcode == ALU_OP_TAG_OR
            |-> ##6 dirty_tag == ($past(dirty_tag) | $past(pixel_alu_data_bus, 5));
    endproperty
    a_tag_or: assert property (p_tag_or) else $error("tag OR wrong");
    property p_mask_load;
        alu_go && pixel_alu_opcode == ALU_OP_WREG_PLANE_MASK
            |-> ##1 $stable(plane_mask)[*5] ##1 plane_mask == $past(pixel_alu_data_bus, 5);
    endproperty
    a_mask_load: assert property (p_mask_load) else $error("mask load timing wrong");
    property p_wb2;
        wb_go && op2 |-> ##1 gbus_write_valid && gbus_beat == 2'h0
            ##1 gbus_write_valid && gbus_beat == 2'h1;
    endproperty
    a_wb2: assert property (p_wb2) else $error("short block beats wrong");
    property p_wb3;
        wb_go && op3 |-> ##1 gbus_write_valid [*3] ##0 gbus_beat == 2'h2;
    endproperty
    a_wb3: assert property (p_wb3) else $error("long block beats wrong");
    property p_mask_use;
        wb_go && opm |-> ##1 gbus_write_enable == {REP{$past(plane_mask)}}
            ##1 gbus_write_enable == {REP{$past(plane_mask, 2)}};
    endproperty
    a_mask_use: assert property (p_mask_use) else $error("block mask wrong");
    property p_unmasked;
        wb_go && (op2 || op3) && !opm |-> ##1 &gbus_write_enable;
    endproperty
    a_unmasked: assert property (p_unmasked) else $error("unmasked enable wrong");
    property p_data;
        gbus_write_valid |-> gbus_write_data == ($past(pbuf_read_data) & gbus_write_enable);
    endproperty
    a_data: assert property (p_data) else $error("bus data wrong");
    property p_idle;
        !gbus_write_valid |-> gbus_write_enable == '0 && gbus_beat == 2'h0 && !wb_busy;
    endproperty
    a_idle: assert property (p_idle) else $error("idle bus not quiet");
    property p_refuse;
        array_cmd_valid && (op2 || op3) && gbus_write_valid && gbus_beat == 2'h0 |=> wb_refused;
    endproperty
    a_refuse: assert property (p_refuse) else $error("refusal missing");
    c_chain: cover property (array_cmd_valid && gbus_write_valid && gbus_beat == 2'h2);
    c_refuse: cover property (wb_refused);
    c_mask: cover property (wb_go && opm && op3);
endmodule // pai_interlock_checker

bind pai_pixel_alu_dram_interlock pai_interlock_checker #(.GB_W(GB_W)) chk_u (.clock, .rst_n,
    .pixel_alu_cmd_valid, .pixel_alu_write_select, .pixel_alu_opcode, .pixel_alu_data_bus,
    .array_cmd_valid, .array_opcode, .pbuf_read_data, .gbus_write_valid, .gbus_write_data,
    .gbus_write_enable, .gbus_beat, .wb_busy, .wb_refused, .dirty_tag, .plane_mask);

/* tb/test_pai_pixel_alu_dram_interlock.sv */
// Self-checking bench for the pixel ALU and block write interlock
`timescale 1ns/1ns
module test_pai_pixel_alu_dram_interlock import pai_pkg::*;;
    localparam int GB_W = GB_W_DEF;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic cv, ws, av, gv, busy, refused;
    logic [ALU_OP_W-1:0] op;
    logic [AOP_W-1:0] aop;
    logic [DATA_W-1:0] dq, tag, mask;
    logic [GB_W-1:0] pbuf, gdata, gen;
    logic [BEAT_W-1:0] idx, beat;
    always #25 clock = ~clock;
    // Hang guard, far above the hundred or so cycles the run needs
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            bad_count++;
            give_verdict();
        end
    end
    pai_ctrl_model #(.GB_W(GB_W)) ctl_u (.clock(clock), .pbuf_read_index(idx),
        .pixel_alu_cmd_valid(cv), .pixel_alu_write_select(ws), .pixel_alu_opcode(op),
        .pixel_alu_data_bus(dq), .array_cmd_valid(av), .array_opcode(aop), .pbuf_read_data(pbuf));
    pai_pixel_alu_dram_interlock #(.GB_W(GB_W)) dut_u (.clock(clock), .rst_n(rst_n),
        .pixel_alu_cmd_valid(cv), .pixel_alu_write_select(ws), .pixel_alu_opcode(op),
        .pixel_alu_data_bus(dq), .array_cmd_valid(av), .array_opcode(aop), .pbuf_read_data(pbuf),
        .pbuf_read_index(idx), .gbus_write_valid(gv), .gbus_write_data(gdata),
        .gbus_write_enable(gen), .gbus_beat(beat), .wb_busy(busy), .wb_refused(refused),
        .dirty_tag(tag), .plane_mask(mask));
    task automatic give_verdict();
        if (bad_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One ALU command at cycle 0, one block at cycle k; outputs read mid-cycle
    task automatic run(input logic w, input logic [ALU_OP_W-1:0] o, input logic [31:0] d,
        input int k, input logic [AOP_W-1:0] a, input int len, input logic [31:0] em,
        input logic sel, input logic [31:0] old_v, input logic [31:0] new_v);
        int last;
        last = (k + len + 1 > 6) ? k + len + 1 : 6;
        for (int i = 0; i <= last; i++) begin
            ctl_u.step(i == 0, w, o, i == 1, d, i == k, a);
            if (i > k && i <= k + len) begin
                check("beat valid", 32'h1, {31'h0, gv});
                check("beat busy", 32'h1, {31'h0, busy});
                check("beat index", 32'(i - k - 1), {30'h0, beat});
                check("beat enable", em, gen[31:0]);
                check("beat data", {24'h5A5A5A, 8'(i - k - 1)} & em, gdata[31:0]);
            end
            if (i == k + len + 1) check("bus idle", 32'h0, {31'h0, gv});
            if (i == 5) check("before commit", old_v, sel ? mask : tag);
            if (i == 6) check("after commit", new_v, sel ? mask : tag);
        end
    endtask
    task automatic t_tag();
        run(1'b1, ALU_OP_TAG_REPLACE, 32'h0000F0F0, 6, AOP_WB2_UNMASKED, 2, MASK_ALL, 1'b0,
            32'h0, 32'h0000F0F0);
        run(1'b1, ALU_OP_TAG_OR, 32'h0F000001, 6, AOP_WB3_MASKED, 3, MASK_ALL, 1'b0,
            32'h0000F0F0, 32'h0F00F0F1);
    endtask
    // block offsets kept clear of the load
    task automatic t_mask_old();
        run(1'b1, ALU_OP_WREG_PLANE_MASK, 32'h00FF00FF, 3, AOP_WB2_MASKED, 2, MASK_ALL, 1'b1,
            MASK_RESET, 32'h00FF00FF);
        run(1'b1, ALU_OP_WREG_PLANE_MASK, 32'h12345678, 2, AOP_WB3_MASKED, 3, 32'h00FF00FF,
            1'b1, 32'h00FF00FF, 32'h12345678);
    endtask
    task automatic t_mask_new();
        run(1'b1, ALU_OP_WREG_PLANE_MASK, 32'hF0F0F0F0, 6, AOP_WB2_MASKED, 2, 32'hF0F0F0F0,
            1'b1, 32'h12345678, 32'hF0F0F0F0);
        run(1'b1, ALU_OP_WREG_PLANE_MASK, 32'h0000FFFF, 6, AOP_WB3_MASKED, 3, 32'h0000FFFF,
            1'b1, 32'hF0F0F0F0, 32'h0000FFFF);
    endtask
    // Write select low and an unknown opcode leave the tag alone
    task automatic t_ignored();
        run(1'b0, ALU_OP_TAG_REPLACE, 32'hAAAAAAAA, 6, AOP_WB3_UNMASKED, 3, MASK_ALL, 1'b0,
            32'h0F00F0F1, 32'h0F00F0F1);
        run(1'b1, 4'h7, 32'h55555555, 6, AOP_WB2_UNMASKED, 2, MASK_ALL, 1'b0,
            32'h0F00F0F1, 32'h0F00F0F1);
    endtask
    // Long block, a refused command on beat 0, a chained one on the last beat
    task automatic t_refuse();
        for (int i = 0; i <= 6; i++) begin
            ctl_u.step(1'b0, 1'b1, 4'h0, 1'b0, 32'h0, i == 0 || i == 1 || i == 3,
                i == 0 ? AOP_WB3_UNMASKED : AOP_WB2_UNMASKED);
            if (i >= 1 && i <= 5) check("chain valid", 32'h1, {31'h0, gv});
            if (i == 2) check("refused", 32'h1, {31'h0, refused});
            if (i == 4) check("chain beat", 32'h0, {30'h0, beat});
            if (i == 6) check("chain idle", 32'h0, {31'h0, gv});
        end
    endtask
    initial begin
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
        check("tag reset", 32'h00000000, tag);
        check("mask reset", 32'hFFFFFFFF, mask);
        t_tag();
        t_mask_old();
        t_mask_new();
        t_ignored();
        t_refuse();
        give_verdict();
    end
endmodule // test_pai_pixel_alu_dram_interlock
